/* dv/tb_temperature_fault_response.sv */
// Self-checking bench of the temperature fault response block
`timescale 1ns/100ps
`default_nettype none
module tb_temperature_fault_response;
    import tfr_pkg::*;
    logic clk, linkClk, nrst, cmdValid, cmdReady, rspValid, intOtPin;
    logic retryTick, alertN, cmlFault, timedOut;
    logic [15:0] rspData, d;
    logic [1:0] extOtPin, extUtPin, runPin, opOn, outEnable;
    logic [7:0] v, intReg, cc;
    tfr_cmd_t cmd;
    tfr_flags_t alertMask;
    tfr_flags_t [1:0] faultFlags;
    int n_mismatch = 0;
    int check_count = 0;
    tfr_core #(.UT_SAMPLE_CYC(16)) dut (.clk(clk), .nrst(nrst),
        .linkClk(linkClk), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmd(cmd), .rspValid(rspValid), .rspData(rspData),
        .intOtPin(intOtPin), .extOtPin(extOtPin), .extUtPin(extUtPin),
        .runPin(runPin), .opOn(opOn), .retryTick(retryTick),
        .alertMask(alertMask), .outEnable(outEnable), .alertN(alertN),
        .faultFlags(faultFlags), .cmlFault(cmlFault));
    tfr_host_model host (.linkClk(linkClk), .cmdReady(cmdReady),
        .rspValid(rspValid), .rspData(rspData), .cmdValid(cmdValid),
        .cmd(cmd), .timedOut(timedOut));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #7;
        forever #32 linkClk = ~linkClk;
    end
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (timedOut) n_mismatch++;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic xf(input logic w, input logic [7:0] c, input logic p,
            input logic [7:0] dt);
        host.xfer({w, c, p, dt}, d);
        if (timedOut) close_out();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Refused writes leave the stored byte alone; delay bits read as zero
    function automatic logic [7:0] int_exp(input logic [7:0] old, nv);
        if (nv[7:6] < 2'h2 || nv[5:3] != RETRY_NONE) return old;
        return {nv[7:6], 6'h00};
    endfunction
    ////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        intOtPin = 1'b0;
        retryTick = 1'b0;
        alertMask = '0;
        extOtPin = 2'h0;
        extUtPin = 2'h0;
        runPin = 2'h3;
        opOn = 2'h3;
        v = 8'($urandom(32'hdddc));
        // Link side needs several of its own edges inside reset
        repeat (6) @(posedge linkClk);
        #1;
        nrst = 1'b1;
        xf(0, CMD_INT_OT_RESP, 0, 8'h00);
        chk("int resp reset", d, 16'h00c0);
        for (int i = 0; i < 4; i++) begin
            cc = i[1] ? CMD_EXT_UT_RESP : CMD_EXT_OT_RESP;
            v = 8'($urandom);
            xf(0, cc, i[0], 8'h00);
            chk("ext resp reset", d, {8'h00, EXT_RESP_RESET});
            xf(1, cc, i[0], v);
            xf(0, cc, i[0], 8'h00);
            chk("ext resp rw", d, {8'h00, v});
            xf(1, cc, i[0], EXT_RESP_RESET);
        end
        intReg = INT_RESP_RESET;
        for (int r = 0; r < 8; r++) begin
            v = 8'($urandom);
            v[7:6] = r[1:0];
            if (r > 3) v[5:3] = RETRY_NONE;
            xf(1, CMD_CLEAR_FAULTS, 0, 8'h00);
            xf(1, CMD_INT_OT_RESP, 0, v);
            intReg = int_exp(intReg, v);
            xf(0, CMD_INT_OT_RESP, 0, 8'h00);
            chk("int resp", d, {8'h00, intReg});
            xf(0, CMD_STATUS_CML, 0, 8'h00);
            chk("cml", d[SC_INVALID],
                v[7:6] < 2'h2 || v[5:3] != 3'h0);
            chk("cml out", cmlFault, d[SC_INVALID]);
        end
        xf(1, CMD_CLEAR_FAULTS, 0, 8'h00);
        intOtPin = 1'b1;
        cyc(8);
        chk("int off", outEnable, 2'h0);
        chk("int flags",
            {faultFlags[1].intOt, faultFlags[0].intOt}, 2'h3);
        chk("alert", alertN, 1'b0);
        xf(0, CMD_STATUS_WORD, 0, 8'h00);
        chk("status word", {d[SW_MFR], d[SB_NOA]}, 2'h3);
        xf(0, CMD_STATUS_MFR, 0, 8'h00);
        chk("mfr ot", d[SM_OT], 1'b1);
        intOtPin = 1'b0;
        cyc(8);
        chk("int resume", outEnable, 2'h3);
        chk("int latched", faultFlags[0].intOt, 1'b1);
        xf(1, CMD_CLEAR_FAULTS, 0, 8'h00);
        chk("alert cleared", alertN, 1'b1);
        xf(1, CMD_EXT_OT_RESP, 0, 8'h80);
        extOtPin = 2'h3;
        cyc(8);
        chk("ext off", outEnable, 2'h0);
        xf(0, CMD_STATUS_TEMP, 0, 8'h00);
        chk("temp ot", d[ST_OT], 1'b1);
        xf(0, CMD_STATUS_BYTE, 0, 8'h00);
        chk("byte temp", d[SB_TEMP], 1'b1);
        extOtPin = 2'h0;
        cyc(8);
        retryTick = 1'b1;
        cyc(1);
        retryTick = 1'b0;
        cyc(6);
        chk("retry", outEnable, 2'h2);
        runPin[0] = 1'b0;
        cyc(6);
        runPin[0] = 1'b1;
        cyc(8);
        chk("off on", outEnable, 2'h3);
        chk("off on flags",
            {faultFlags[1].extOt, faultFlags[0].extOt}, 2'h2);
        xf(1, CMD_CLEAR_FAULTS, 0, 8'h00);
        alertMask = 3'h1;
        extUtPin[1] = 1'b1;
        cyc(28);
        chk("ut flag", faultFlags[1].extUt, 1'b1);
        chk("ut masked", alertN, 1'b1);
        xf(0, CMD_STATUS_TEMP, 1, 8'h00);
        chk("temp ut", {d[ST_UT], outEnable[1]}, 2'h2);
        alertMask = 3'h0;
        cyc(2);
        chk("ut alert", alertN, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire

/* dv/tfr_checker_assertions.sv */
// Concurrent checks on the temperature fault response ports
`timescale 1ns/100ps
`default_nettype none
module tfr_checker
    import tfr_pkg::*;
#(
    parameter int UT_SAMPLE_CYC = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic intOtPin,
    input wire logic [tfr_pkg::NPAGE-1:0] extOtPin,
    input wire logic [tfr_pkg::NPAGE-1:0] extUtPin,
    input wire logic [tfr_pkg::NPAGE-1:0] runPin,
    input wire logic [tfr_pkg::NPAGE-1:0] opOn,
    input wire tfr_pkg::tfr_flags_t alertMask,
    input wire logic [tfr_pkg::NPAGE-1:0] outEnable,
    input wire logic alertN,
    input wire tfr_pkg::tfr_flags_t [tfr_pkg::NPAGE-1:0] faultFlags,
    input wire logic cmlFault
);
    // Sample point plus synchroniser slack
    localparam int UT_BOUND = UT_SAMPLE_CYC + 8;
    logic [3:0] sinceOn_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles since page 0 run and operation both turned on, held at 15
    always_ff @(posedge clk) begin
        if (!nrst || !(runPin[0] && opOn[0])) begin
            sinceOn_q <= 4'h0;
        end else if (sinceOn_q != 4'hf) begin
            sinceOn_q <= sinceOn_q + 4'h1;
        end
    end
    ////////////////////////////////////////
    a_alert_from_flags: assert property ($stable(alertMask) |-> ##[0:1]
        alertN == !(cmlFault || |(faultFlags & ~{NPAGE{alertMask}})))
        else $error("alert does not follow unmasked flags");
    a_intot_flags: assert property (intOtPin[*5] |->
        faultFlags[0].intOt && faultFlags[1].intOt)
        else $error("internal overtemp flag missing");
    a_intot_off: assert property (intOtPin[*5] |-> outEnable == 2'h0)
        else $error("output on during internal overtemp");
    a_extot_flag: assert property (extOtPin[0][*5] |->
        faultFlags[0].extOt)
        else $error("external overtemp flag missing");
    a_ut_lag: assert property ($rose(extUtPin[1]) |-> ##[1:UT_BOUND]
        (faultFlags[1].extUt || !extUtPin[1]))
        else $error("undertemp flag too late");
    a_ut_cause: assert property ($rose(faultFlags[1].extUt) |->
        $past(extUtPin[1], 2) || $past(extUtPin[1], 3)
        || $past(extUtPin[1], 4))
        else $error("undertemp flag without pin");
    a_flag_holds: assert property ($fell(faultFlags[0].extOt) |->
        !cmdReady || sinceOn_q < 4'h8)
        else $error("latched flag cleared without cause");
    a_cml_busy: assert property ($rose(cmlFault) |-> !cmdReady)
        else $error("cml fault outside a command");
    c_cmd: cover property (cmdValid && cmdReady);
    c_cml: cover property ($rose(cmlFault));
    c_ut: cover property ($rose(faultFlags[1].extUt));
endmodule
bind tfr_core tfr_checker #(.UT_SAMPLE_CYC(UT_SAMPLE_CYC)) u_chk (
    .clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .intOtPin(intOtPin), .extOtPin(extOtPin), .extUtPin(extUtPin),
    .runPin(runPin), .opOn(opOn), .alertMask(alertMask),
    .outEnable(outEnable), .alertN(alertN), .faultFlags(faultFlags),
    .cmlFault(cmlFault));
`default_nettype wire

/* dv/tfr_host_model.sv */
// Host model issuing one command at a time on the link clock
`timescale 1ns/100ps
`default_nettype none
module tfr_host_model
    import tfr_pkg::*;
(
    input wire logic linkClk,
    input wire logic cmdReady,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    output logic cmdValid,
    output tfr_pkg::tfr_cmd_t cmd,
    output logic timedOut
);
    initial begin
        cmdValid = 1'b0;
        cmd = '0;
        timedOut = 1'b0;
    end
    // Fields are inverted once taken so stale values are never trusted
    task automatic xfer(input tfr_cmd_t c, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge linkClk);
        #1;
        while (!cmdReady && n < 60) begin
            @(posedge linkClk);
            #1;
            n++;
        end
        cmdValid = 1'b1;
        cmd = c;
        @(posedge linkClk);
        #1;
        cmdValid = 1'b0;
        cmd = ~c;
        while (!rspValid && n < 60) begin
            @(posedge linkClk);
            #1;
            n++;
        end
        d = rspData;
        if (n >= 60) timedOut = 1'b1;
    endtask
endmodule
`default_nettype wire

/* hw/tfr_core.sv */
// Temperature fault response logic with its command port on the link clock
`timescale 1ns/100ps
`default_nettype none
module tfr_core #(
    parameter int UT_SAMPLE_CYC = tfr_pkg::UT_LAG_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic linkClk,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire tfr_pkg::tfr_cmd_t cmd,
    output logic rspValid,
    output logic [15:0] rspData,
    input wire logic intOtPin,
    input wire logic [tfr_pkg::NPAGE-1:0] extOtPin,
    input wire logic [tfr_pkg::NPAGE-1:0] extUtPin,
    input wire logic [tfr_pkg::NPAGE-1:0] runPin,
    input wire logic [tfr_pkg::NPAGE-1:0] opOn,
    input wire logic retryTick,
    input wire tfr_pkg::tfr_flags_t alertMask,
    output logic [tfr_pkg::NPAGE-1:0] outEnable,
    output logic alertN,
    output tfr_pkg::tfr_flags_t [tfr_pkg::NPAGE-1:0] faultFlags,
    output logic cmlFault
);
    import tfr_pkg::*;

    localparam int PINW = 1 + 3 * NPAGE;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: takes a command, hands it over, returns the answer

    typedef enum logic [1:0] {
        LK_IDLE = 2'b01,
        LK_BUSY = 2'b10
    } tfr_lstate_t;

    typedef struct packed {
        logic [1:0] rstSync;
        tfr_lstate_t st;
        tfr_cmd_t cmd;
        logic reqTgl;
        logic ackMeta;
        logic ackSync;
        logic ackSeen;
        logic rspValid;
        logic [15:0] rspData;
    } tfr_link_t;

    // Core domain
    typedef struct packed {
        logic reqMeta;
        logic reqSync;
        logic reqSeen;
        logic ackTgl;
        logic [15:0] rspData;
        logic [PINW-1:0] pinMeta;
        logic [PINW-1:0] pinSync;
        logic [7:0] intResp;
        logic [NPAGE-1:0][7:0] otResp;
        logic [NPAGE-1:0][7:0] utResp;
        tfr_flags_t [NPAGE-1:0] flags;
        logic cml;
        logic [NPAGE-1:0] intShut;
        logic [NPAGE-1:0] extShut;
        logic [NPAGE-1:0] onPrev;
        logic [NPAGE-1:0] utSmp;
        logic [31:0] utCnt;
        logic [NPAGE-1:0] outEn;
    } tfr_state_t;

    tfr_link_t lk_q, lk_d;
    tfr_state_t s_q, s_d;

    always_comb begin
        lk_d = lk_q;
        lk_d.rstSync = {lk_q.rstSync[0], nrst};
        lk_d.ackMeta = s_q.ackTgl;
        lk_d.ackSync = lk_q.ackMeta;
        lk_d.rspValid = 1'b0;
        case (lk_q.st)
            LK_IDLE: begin
                if (cmdValid) begin
                    lk_d.cmd = cmd;
                    lk_d.reqTgl = ~lk_q.reqTgl;
                    lk_d.st = LK_BUSY;
                end
            end
            LK_BUSY: begin
                if (lk_q.ackSync != lk_q.ackSeen) begin
                    // Core holds its answer steady until the next request
                    lk_d.ackSeen = lk_q.ackSync;
                    lk_d.rspData = s_q.rspData;
                    lk_d.rspValid = 1'b1;
                    lk_d.st = LK_IDLE;
                end
            end
            default: lk_d.st = LK_IDLE;
        endcase
        if (!lk_q.rstSync[1]) begin
            lk_d.st = LK_IDLE;
            lk_d.cmd = '0;
            lk_d.reqTgl = 1'b0;
            lk_d.ackSeen = 1'b0;
            lk_d.rspData = 16'h0000;
        end
    end

    always_ff @(posedge linkClk) begin
        lk_q <= lk_d;
    end

    assign cmdReady = (lk_q.st == LK_IDLE) && lk_q.rstSync[1];
    assign rspValid = lk_q.rspValid;
    assign rspData = lk_q.rspData;

    ////////////////////////////////////////////////////////////////////////
    // Core domain

    logic intOtNow;
    logic [NPAGE-1:0] extOtNow, extUtNow, runNow, onNow, onRise;
    logic [NPAGE-1:0] intHold, otHold, utHold;
    logic reqEv, clearAll, wrCml;
    logic [7:0] sbyte [NPAGE];
    logic [7:0] stemp [NPAGE];
    logic [1:0] wResp;
    logic [2:0] wRetry;
    tfr_cmd_t c;

    always_comb begin
        s_d = s_q;
        s_d.pinMeta = {intOtPin, extOtPin, extUtPin, runPin};
        s_d.pinSync = s_q.pinMeta;
        s_d.reqMeta = lk_q.reqTgl;
        s_d.reqSync = s_q.reqMeta;
        {intOtNow, extOtNow, extUtNow, runNow} = s_q.pinSync;
        onNow = runNow & opOn;
        onRise = onNow & ~s_q.onPrev;
        s_d.onPrev = onNow;
        c = lk_q.cmd;
        reqEv = s_q.reqSync != s_q.reqSeen;
        wResp = c.data[RESP_HI:RESP_LO];
        wRetry = c.data[RETRY_HI:RETRY_LO];
        clearAll = 1'b0;
        wrCml = 1'b0;

        // Undertemperature is only seen at the converter sample instants
        if (s_q.utCnt >= 32'(UT_SAMPLE_CYC - 1)) begin
            s_d.utCnt = 32'h0;
            s_d.utSmp = extUtNow;
        end else begin
            s_d.utCnt = s_q.utCnt + 32'h1;
        end

        for (int p = 0; p < NPAGE; p++) begin
            sbyte[p] = 8'h00;
            sbyte[p][SB_NOA] = s_q.flags[p].intOt;
            sbyte[p][SB_CML] = s_q.cml;
            sbyte[p][SB_TEMP] = s_q.flags[p].extOt | s_q.flags[p].extUt;
            stemp[p] = 8'h00;
            stemp[p][ST_OT] = s_q.flags[p].extOt;
            stemp[p][ST_UT] = s_q.flags[p].extUt;
        end

        if (reqEv) begin
            s_d.reqSeen = s_q.reqSync;
            s_d.ackTgl = ~s_q.ackTgl;
            s_d.rspData = 16'h0000;
            case (c.code)
                CMD_CLEAR_FAULTS: begin
                    if (c.write) begin
                        clearAll = 1'b1;
                    end
                end
                CMD_INT_OT_RESP: begin
                    if (c.write) begin
                        if (wResp == RESP_CONTINUE
                            || wResp == RESP_DEGLITCH) begin
                            wrCml = 1'b1;
                        end else if (wRetry != RETRY_NONE) begin
                            wrCml = 1'b1;
                        end else begin
                            // Delay bits are dropped, so they read as 0
                            s_d.intResp = {c.data[7:3], 3'h0};
                        end
                    end
                    s_d.rspData = {8'h00, s_q.intResp};
                end
                CMD_EXT_OT_RESP: begin
                    if (c.write) begin
                        s_d.otResp[c.page] = c.data;
                    end
                    s_d.rspData = {8'h00, s_q.otResp[c.page]};
                end
                CMD_EXT_UT_RESP: begin
                    if (c.write) begin
                        s_d.utResp[c.page] = c.data;
                    end
                    s_d.rspData = {8'h00, s_q.utResp[c.page]};
                end
                CMD_STATUS_BYTE: begin
                    s_d.rspData = {8'h00, sbyte[c.page]};
                end
                CMD_STATUS_WORD: begin
                    s_d.rspData = {8'h00, sbyte[c.page]};
                    s_d.rspData[SW_MFR] = s_q.flags[c.page].intOt;
                end
                CMD_STATUS_TEMP: begin
                    s_d.rspData = {8'h00, stemp[c.page]};
                end
                CMD_STATUS_MFR: begin
                    s_d.rspData[SM_OT] = s_q.flags[c.page].intOt;
                end
                CMD_STATUS_CML: begin
                    s_d.rspData[SC_INVALID] = s_q.cml;
                end
                default: begin
                    wrCml = 1'b1;
                end
            endcase
        end

        // A fault arriving with a clear still latches
        if (clearAll) begin
            s_d.cml = 1'b0;
        end
        if (wrCml) begin
            s_d.cml = 1'b1;
        end

        for (int p = 0; p < NPAGE; p++) begin
            if (clearAll || onRise[p]) begin
                s_d.flags[p] = '0;
                s_d.intShut[p] = 1'b0;
                s_d.extShut[p] = 1'b0;
            end
            // Hold decoding is common to all three bytes; shutdown is 10 internally, 01 or 10 externally
            intHold[p] = intOtNow
                && s_q.intResp[RESP_HI:RESP_LO] == RESP_WHILE_ON;
            otHold[p] = extOtNow[p]
                && s_q.otResp[p][RESP_HI:RESP_LO] == RESP_WHILE_ON;
            utHold[p] = s_q.utSmp[p]
                && s_q.utResp[p][RESP_HI:RESP_LO] == RESP_WHILE_ON;
            if (intOtNow) begin
                s_d.flags[p].intOt = 1'b1;
                if (s_q.intResp[RESP_HI:RESP_LO] == RESP_SHUTDOWN) begin
                    s_d.intShut[p] = 1'b1;
                end
            end
            if (extOtNow[p]) begin
                s_d.flags[p].extOt = 1'b1;
            end
            if (s_q.utSmp[p]) begin
                s_d.flags[p].extUt = 1'b1;
            end
            if ((extOtNow[p]
                && s_q.otResp[p][RESP_HI] != s_q.otResp[p][RESP_LO])
                || (s_q.utSmp[p]
                && s_q.utResp[p][RESP_HI] != s_q.utResp[p][RESP_LO])) begin
                s_d.extShut[p] = 1'b1;
            end else if (s_q.extShut[p] && retryTick
                && s_q.otResp[p][RETRY_HI:RETRY_LO] != RETRY_NONE
                && s_q.utResp[p][RETRY_HI:RETRY_LO] != RETRY_NONE) begin
                // Both retry fields must allow restart; 000 holds it off
                s_d.extShut[p] = 1'b0;
            end
            s_d.outEn[p] = onNow[p] && !s_d.intShut[p] && !s_d.extShut[p]
                && !intHold[p] && !otHold[p] && !utHold[p];
        end

        if (!nrst) begin
            s_d = '0;
            s_d.intResp = INT_RESP_RESET;
            for (int p = 0; p < NPAGE; p++) begin
                s_d.otResp[p] = EXT_RESP_RESET;
                s_d.utResp[p] = EXT_RESP_RESET;
            end
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    logic alertAny;
    always_comb begin
        alertAny = 1'b0;
        for (int p = 0; p < NPAGE; p++) begin
            alertAny = alertAny
                || (s_q.flags[p].intOt && !alertMask.intOt)
                || (s_q.flags[p].extOt && !alertMask.extOt)
                || (s_q.flags[p].extUt && !alertMask.extUt);
        end
    end

    assign alertN = ~(alertAny | s_q.cml);
    assign outEnable = s_q.outEn;
    assign faultFlags = s_q.flags;
    assign cmlFault = s_q.cml;
endmodule
`default_nettype wire

/* pkg/tfr_pkg.sv */
// Constants, codes and carrier types of the temperature fault response block
// Operation
// - One byte selects the reaction to internal die overtemperature.
// - Internal overtemp sets byte NOA, word MFR and MFR overtemp flags.
// - Each temperature fault asserts alert unless that fault is masked.
// - Internal response field is bits 7:6; writing 00 or 01 raises CML.
// - Shutdown response disables output at once, then obeys retry 5:3.
// - Response 11 holds output off while fault persists, then resumes.
// - Latched flags clear only by clear-faults, off-then-on, or reset.
// - Retry 000 makes no restart; output stays off until cleared.
// - Internal response byte: any retry code but 000 raises CML.
// - Internal response delay field 2:0 is ignored.
// - External overtemp response: paged byte, code 0x50, default 0xB8.
// - External undertemp response: paged byte, code 0x54, default 0xB8.
// - External overtemp sets byte temperature and temp-status overtemp.
// - External undertemp sets byte temperature and temp-status undertemp.
// - Undertemperature reaction may lag the condition by up to 90 ms.
// - Internal response byte sits at code 0xD6, default 0xC0.
package tfr_pkg;
    localparam int NPAGE = 2;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_EXT_OT_RESP = 8'h50;
    localparam logic [7:0] CMD_EXT_UT_RESP = 8'h54;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7d;
    localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
    localparam logic [7:0] CMD_STATUS_MFR = 8'h80;
    localparam logic [7:0] CMD_INT_OT_RESP = 8'hd6;
    localparam logic [7:0] EXT_RESP_RESET = 8'hb8;
    localparam logic [7:0] INT_RESP_RESET = 8'hc0;
    // Field positions shared by all response bytes
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam logic [1:0] RESP_CONTINUE = 2'h0;
    localparam logic [1:0] RESP_DEGLITCH = 2'h1;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_WHILE_ON = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    // Status bit positions
    localparam int SB_NOA = 0;
    localparam int SB_CML = 1;
    localparam int SB_TEMP = 2;
    localparam int SW_MFR = 12;
    localparam int ST_OT = 7;
    localparam int ST_UT = 4;
    localparam int SM_OT = 6;
    localparam int SC_INVALID = 7;
    localparam int UT_LAG_MS = 90;
    localparam int CLK_MHZ = 250;
    localparam int UT_LAG_CYC = UT_LAG_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic page;
        logic [7:0] data;
    } tfr_cmd_t;

    typedef struct packed {
        logic intOt;
        logic extOt;
        logic extUt;
    } tfr_flags_t;
endpackage
